// >>> include/task_switch_regs.vh
`ifndef TASK_SWITCH_REGS_VH
`define TASK_SWITCH_REGS_VH

// ==================================================
// Register offsets
`define OFF_CTRL    8'h00
`define OFF_STAT    8'h04
`define OFF_TRSEL   8'h08
`define OFF_TRBASE  8'h0c
`define OFF_TRLIM   8'h10
`define OFF_LTR     8'h14
`define OFF_PTB     8'h18
`define OFF_GDTB    8'h20
`define OFF_LDTB    8'h24
`define OFF_IDTB    8'h28
`define CTX_WIN     2'h1

// ==================================================
// Field positions and reset values
`define CTRL_LAZY   0
`define CTRL_LONG   1
`define STAT_BUSY   0
`define DESC_P      15
`define DESC_BUSY   9
`define EFL_NT      14
`define RST_WORD    32'h00000000
`define RST_SEL     16'h0000

// ==================================================
// Descriptor types and task state segment layout
`define TYPE_GATE   5'h05
`define TYPE_STD_M  5'h1d
`define TYPE_STD    5'h09
`define ST_MINLIM   20'h00067
`define ST_LINK     32'h00000000
`define ST_PTB      32'h0000001c
`define ST_CTX      32'h00000020
`define ST_LTR      32'h00000060
`define DESC_HI     32'h00000004
`define CTX_FLAGS   4'h1
`define CTX_SEG0    4'ha
`define CTX_CS      4'hb
`define CTX_LAST    5'h0f
`define LD_PTB      5'h10
`define LD_LAST     5'h11
`define SEG_LAST    5'h05

// ==================================================
// Fault codes and switch causes
`define FLT_NONE    3'h0
`define FLT_PR      3'h1
`define FLT_AB      3'h2
`define FLT_IS      3'h3
`define FLT_CU      3'h4
`define K_JUMP      3'h0
`define K_CALL      3'h1
`define K_SWINT     3'h2
`define K_HWINT     3'h3
`define K_IRTN      3'h4

`endif

// >>> rtl/task_switch_sequencer.v
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "task_switch_regs.vh"
module task_switch_sequencer (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_we_in,
  input  wire        reg_re_in,
  output reg  [31:0] reg_rdata_out,
  input  wire        sw_start_in,
  input  wire [2:0]  sw_kind_in,
  input  wire [15:0] sw_sel_in,
  input  wire [7:0]  sw_vec_in,
  input  wire        media_op_in,
  output wire        busy_out,
  output reg         fault_out,
  output reg  [2:0]  fault_code_out,
  output reg         resume_out,
  output reg  [15:0] resume_cs_out,
  output reg  [31:0] resume_ip_out,
  output reg         lazy_context_flag_out,
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [31:0] mem_addr_out,
  output reg  [31:0] mem_wdata_out,
  input  wire        mem_ack_in,
  input  wire [31:0] mem_rdata_in
);

  // ==================================================
  // States
  localparam S_IDLE = 13'h0001;
  localparam S_LRD  = 13'h0002;
  localparam S_DRD  = 13'h0004;
  localparam S_CHK  = 13'h0008;
  localparam S_SAVE = 13'h0010;
  localparam S_TRLD = 13'h0020;
  localparam S_OLDR = 13'h0040;
  localparam S_OLDW = 13'h0080;
  localparam S_NEWB = 13'h0100;
  localparam S_LOAD = 13'h0200;
  localparam S_LINK = 13'h0400;
  localparam S_SEG  = 13'h0800;
  localparam S_DONE = 13'h1000;
  localparam MEM_ST = 13'h0fd6;

  reg [12:0] state;
  reg [31:0] ctx [0:15];
  reg [31:0] dlo;
  reg [31:0] dhi;
  reg [31:0] old_hi;
  reg        half;
  reg        stage;
  reg [4:0]  idx;
  reg [2:0]  kind;
  reg [15:0] sel;
  reg [7:0]  vec;
  reg [15:0] old_sel;
  reg        post_flt;
  reg        long_mode;
  reg [15:0] task_sel;
  reg [31:0] task_base;
  reg [19:0] task_lim;
  reg [15:0] ltr;
  reg [31:0] ptb;
  reg [31:0] gbase;
  reg [31:0] lbase;
  reg [31:0] ibase;
  reg [5:0]  seg_present;
  reg [2:0]  last_flt;
  reg [2:0]  chk_flt;
  reg        via_gate;
  reg [31:0] next_addr;
  reg        next_we;
  reg [31:0] next_wdata;
  reg [31:0] rd_val;
  integer    i;

  // ==================================================
  // Descriptor decode
  wire [4:0]  typ      = {dhi[12], dhi[11:8]};
  wire        pres     = dhi[`DESC_P];
  wire [1:0]  dsc_lvl  = dhi[14:13];
  wire [19:0] lim      = {dhi[19:16], dlo[15:0]};
  wire [31:0] nbase    = {dhi[31:24], dhi[7:0], dlo[31:16]};
  wire [1:0]  cur_lvl  = ctx[`CTX_CS][1:0];
  wire [1:0]  req_lvl  = sel[1:0];
  wire        is_gate  = (typ == `TYPE_GATE);
  wire        is_std   = ((typ & `TYPE_STD_M) == `TYPE_STD);
  wire        explicit = (kind == `K_JUMP) || (kind == `K_CALL);
  wire        is_int   = (kind == `K_SWINT) || (kind == `K_HWINT);
  wire        nest     = (kind == `K_CALL) || is_int;
  wire        free_old = (kind == `K_JUMP) || (kind == `K_IRTN);
  wire        priv_bad = (cur_lvl > dsc_lvl) || (req_lvl > dsc_lvl);
  wire        xfer     = mem_req_out && mem_ack_in;
  wire        mem_st   = |(state & MEM_ST);
  wire [3:0]  seg_i    = idx[3:0] + `CTX_SEG0;
  wire [15:0] seg_sel  = ctx[seg_i][15:0];
  wire [31:0] sel_off  = {16'h0000, sel[15:3], 3'h0};
  wire [31:0] old_off  = {16'h0000, old_sel[15:3], 3'h0};
  wire [31:0] seg_off  = {16'h0000, seg_sel[15:3], 3'h0};
  wire [31:0] vec_off  = {21'h000000, vec, 3'h0};
  wire [31:0] word_off = {25'h0000000, idx, 2'h0};
  wire [31:0] half_off = half ? `DESC_HI : 32'h00000000;
  wire [31:0] tbl_base = (!stage && is_int) ? ibase :
                         (!stage && sel[2]) ? lbase : gbase;
  wire [31:0] desc_adr = tbl_base + ((!stage && is_int) ? vec_off : sel_off);

  assign busy_out = (state != S_IDLE);

  // ==================================================
  // Privilege, type and limit checks
  always @* begin
    chk_flt  = `FLT_NONE;
    via_gate = 1'b0;
    if (!stage && is_gate) begin
      if (!pres)
        chk_flt = `FLT_AB;
      else if (explicit && priv_bad)
        chk_flt = `FLT_PR;
      else
        via_gate = 1'b1;
    end else if (!is_std || (!stage && is_int)) begin
      chk_flt = `FLT_PR;
    end else if (!stage && explicit && sel[2]) begin
      chk_flt = `FLT_PR;
    end else if (!pres) begin
      chk_flt = `FLT_AB;
    end else if (!stage && explicit && priv_bad) begin
      chk_flt = `FLT_PR;
    end else if ((kind != `K_IRTN) && dhi[`DESC_BUSY]) begin
      chk_flt = `FLT_PR;
    end else if (lim < `ST_MINLIM) begin
      chk_flt = `FLT_IS;
    end
  end

  // ==================================================
  // Memory request contents per state
  always @* begin
    next_addr  = 32'h00000000;
    next_we    = 1'b0;
    next_wdata = 32'h00000000;
    case (state)
      S_LRD: begin
        next_addr = task_base + `ST_LINK;
      end
      S_DRD: begin
        next_addr = desc_adr + half_off;
      end
      S_SAVE: begin
        next_we    = 1'b1;
        next_addr  = task_base + `ST_CTX + word_off;
        next_wdata = ctx[idx[3:0]];
        if (idx[3:0] == `CTX_FLAGS && kind == `K_IRTN)
          next_wdata[`EFL_NT] = 1'b0;
      end
      S_OLDR: begin
        next_addr = gbase + old_off + `DESC_HI;
      end
      S_OLDW: begin
        next_we    = 1'b1;
        next_addr  = gbase + old_off + `DESC_HI;
        next_wdata = old_hi & ~(32'h1 << `DESC_BUSY);
      end
      S_NEWB: begin
        // Only state descriptors are written, never a gate
        next_we    = 1'b1;
        next_addr  = gbase + sel_off + `DESC_HI;
        next_wdata = dhi | (32'h1 << `DESC_BUSY);
      end
      S_LOAD: begin
        if (idx == `LD_PTB)
          next_addr = task_base + `ST_PTB;
        else if (idx == `LD_LAST)
          next_addr = task_base + `ST_LTR;
        else
          next_addr = task_base + `ST_CTX + word_off;
      end
      S_LINK: begin
        next_we    = 1'b1;
        next_addr  = task_base + `ST_LINK;
        next_wdata = {16'h0000, old_sel};
      end
      S_SEG: begin
        next_addr = (seg_sel[2] ? lbase : gbase) + seg_off + `DESC_HI;
      end
      default: begin
        next_addr = 32'h00000000;
      end
    endcase
  end

  // ==================================================
  // Register read mux
  always @* begin
    rd_val = 32'h00000000;
    if (reg_addr_in[7:6] == `CTX_WIN) begin
      rd_val = ctx[reg_addr_in[5:2]];
    end else begin
      case (reg_addr_in)
        `OFF_CTRL:   rd_val = {30'h0, long_mode, lazy_context_flag_out};
        `OFF_STAT:   rd_val = {22'h0, seg_present, last_flt, busy_out};
        `OFF_TRSEL:  rd_val = {16'h0000, task_sel};
        `OFF_TRBASE: rd_val = task_base;
        `OFF_TRLIM:  rd_val = {12'h000, task_lim};
        `OFF_LTR:    rd_val = {16'h0000, ltr};
        `OFF_PTB:    rd_val = ptb;
        `OFF_GDTB:   rd_val = gbase;
        `OFF_LDTB:   rd_val = lbase;
        `OFF_IDTB:   rd_val = ibase;
        default:     rd_val = 32'h00000000;
      endcase
    end
  end

  // ==================================================
  // Sequencer
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state                 <= S_IDLE;
      for (i = 0; i < 16; i = i + 1)
        ctx[i] <= `RST_WORD;
      dlo                   <= `RST_WORD;
      dhi                   <= `RST_WORD;
      old_hi                <= `RST_WORD;
      half                  <= 1'b0;
      stage                 <= 1'b0;
      idx                   <= 5'h00;
      kind                  <= `K_JUMP;
      sel                   <= `RST_SEL;
      vec                   <= 8'h00;
      old_sel               <= `RST_SEL;
      post_flt              <= 1'b0;
      long_mode             <= 1'b0;
      task_sel              <= `RST_SEL;
      task_base             <= `RST_WORD;
      task_lim              <= 20'h00000;
      ltr                   <= `RST_SEL;
      ptb                   <= `RST_WORD;
      gbase                 <= `RST_WORD;
      lbase                 <= `RST_WORD;
      ibase                 <= `RST_WORD;
      seg_present           <= 6'h00;
      last_flt              <= `FLT_NONE;
      reg_rdata_out         <= `RST_WORD;
      fault_out             <= 1'b0;
      fault_code_out        <= `FLT_NONE;
      resume_out            <= 1'b0;
      resume_cs_out         <= `RST_SEL;
      resume_ip_out         <= `RST_WORD;
      lazy_context_flag_out <= 1'b0;
      mem_req_out           <= 1'b0;
      mem_we_out            <= 1'b0;
      mem_addr_out          <= `RST_WORD;
      mem_wdata_out         <= `RST_WORD;
    end else begin
      fault_out     <= 1'b0;
      resume_out    <= 1'b0;
      reg_rdata_out <= reg_re_in ? rd_val : 32'h00000000;

      // One access in flight; after an ack the request drops for one cycle before the next
      if (mem_st && !mem_req_out) begin
        mem_req_out   <= 1'b1;
        mem_we_out    <= next_we;
        mem_addr_out  <= next_addr;
        mem_wdata_out <= next_wdata;
      end else if (xfer) begin
        mem_req_out <= 1'b0;
        mem_we_out  <= 1'b0;
      end

      // Software writes only while idle, so a switch sees stable context
      if (reg_we_in && state == S_IDLE) begin
        if (reg_addr_in[7:6] == `CTX_WIN) begin
          ctx[reg_addr_in[5:2]] <= reg_wdata_in;
        end else begin
          case (reg_addr_in)
            `OFF_CTRL: begin
              lazy_context_flag_out <= reg_wdata_in[`CTRL_LAZY];
              long_mode             <= reg_wdata_in[`CTRL_LONG];
            end
            `OFF_TRSEL:  task_sel  <= reg_wdata_in[15:0];
            `OFF_TRBASE: task_base <= reg_wdata_in;
            `OFF_TRLIM:  task_lim  <= reg_wdata_in[19:0];
            `OFF_LTR:    ltr       <= reg_wdata_in[15:0];
            `OFF_PTB:    ptb       <= reg_wdata_in;
            `OFF_GDTB:   gbase     <= reg_wdata_in;
            `OFF_LDTB:   lbase     <= reg_wdata_in;
            `OFF_IDTB:   ibase     <= reg_wdata_in;
            default:     ltr       <= ltr;
          endcase
        end
      end

      case (state)
        S_IDLE: begin
          if (sw_start_in) begin
            kind     <= sw_kind_in;
            sel      <= sw_sel_in;
            vec      <= sw_vec_in;
            stage    <= 1'b0;
            half     <= 1'b0;
            post_flt <= 1'b0;
            if (long_mode) begin
              fault_out      <= 1'b1;
              fault_code_out <= `FLT_PR;
              last_flt       <= `FLT_PR;
            end else if (sw_kind_in == `K_IRTN) begin
              // Plain return without nesting is not a task switch
              if (ctx[`CTX_FLAGS][`EFL_NT])
                state <= S_LRD;
            end else begin
              state <= S_DRD;
            end
          end else if (media_op_in && lazy_context_flag_out) begin
            fault_out      <= 1'b1;
            fault_code_out <= `FLT_CU;
            last_flt       <= `FLT_CU;
          end
        end
        S_LRD: begin
          if (xfer) begin
            sel   <= mem_rdata_in[15:0];
            state <= S_DRD;
          end
        end
        S_DRD: begin
          if (xfer) begin
            half <= ~half;
            if (half) begin
              dhi   <= mem_rdata_in;
              state <= S_CHK;
            end else begin
              dlo <= mem_rdata_in;
            end
          end
        end
        S_CHK: begin
          if (chk_flt != `FLT_NONE) begin
            // Nothing has been written yet, so the abort is clean
            fault_out      <= 1'b1;
            fault_code_out <= chk_flt;
            last_flt       <= chk_flt;
            state          <= S_IDLE;
          end else if (via_gate) begin
            sel   <= dlo[31:16];
            stage <= 1'b1;
            state <= S_DRD;
          end else begin
            idx   <= 5'h00;
            state <= S_SAVE;
          end
        end
        S_SAVE: begin
          if (xfer) begin
            idx <= idx + 5'h01;
            if (idx == `CTX_LAST)
              state <= S_TRLD;
          end
        end
        S_TRLD: begin
          old_sel               <= task_sel;
          task_sel              <= sel;
          task_base             <= nbase;
          task_lim              <= lim;
          lazy_context_flag_out <= 1'b1;
          seg_present           <= 6'h00;
          if (free_old)
            state <= S_OLDR;
          else
            state <= S_NEWB;
        end
        S_OLDR: begin
          if (xfer) begin
            old_hi <= mem_rdata_in;
            state  <= S_OLDW;
          end
        end
        S_OLDW: begin
          if (xfer) begin
            idx <= 5'h00;
            // Returning task was already marked busy
            if (kind == `K_IRTN)
              state <= S_LOAD;
            else
              state <= S_NEWB;
          end
        end
        S_NEWB: begin
          if (xfer) begin
            idx   <= 5'h00;
            state <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (xfer) begin
            idx <= idx + 5'h01;
            if (idx == `LD_PTB)
              ptb <= mem_rdata_in;
            else if (idx == `LD_LAST)
              ltr <= mem_rdata_in[15:0];
            else if (idx[3:0] == `CTX_FLAGS && nest)
              ctx[idx[3:0]] <= mem_rdata_in | (32'h1 << `EFL_NT);
            else
              ctx[idx[3:0]] <= mem_rdata_in;
            if (idx == `LD_LAST) begin
              idx   <= 5'h00;
              state <= nest ? S_LINK : S_SEG;
            end
          end
        end
        S_LINK: begin
          if (xfer)
            state <= S_SEG;
        end
        S_SEG: begin
          if (xfer) begin
            seg_present[idx[2:0]] <= mem_rdata_in[`DESC_P];
            // Belongs to the new task: note it, keep loading
            if (seg_i == `CTX_CS && !mem_rdata_in[`DESC_P])
              post_flt <= 1'b1;
            idx <= idx + 5'h01;
            if (idx == `SEG_LAST)
              state <= S_DONE;
          end
        end
        S_DONE: begin
          resume_out    <= 1'b1;
          resume_cs_out <= ctx[`CTX_CS][15:0];
          resume_ip_out <= ctx[0];
          if (post_flt) begin
            fault_out      <= 1'b1;
            fault_code_out <= `FLT_IS;
            last_flt       <= `FLT_IS;
          end
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // task_switch_sequencer

// >>> dv/task_switch_sequencer_props.sv
`timescale 1ns/1ps
`include "task_switch_regs.vh"
module task_switch_sequencer_props (
  input wire        clk_sys_in,
  input wire        rst_in,
  input wire        reg_we_in,
  input wire        sw_start_in,
  input wire [2:0]  sw_kind_in,
  input wire        media_op_in,
  input wire        busy_out,
  input wire        fault_out,
  input wire [2:0]  fault_code_out,
  input wire        resume_out,
  input wire        lazy_context_flag_out,
  input wire        mem_req_out,
  input wire [31:0] mem_addr_out,
  input wire        mem_ack_in
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // ==================================================
  // Outcome of a switch
  property p_fault_pulse;
    fault_out |=> !fault_out;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault pulse too long");
  property p_resume_pulse;
    resume_out |=> !resume_out;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("resume pulse too long");
  // A refused return gives no answer, so every return is left out here
  property p_switch_ends;
    sw_start_in && !busy_out && sw_kind_in != `K_IRTN |-> ##[1:1000] (fault_out || resume_out);
  endproperty
  a_switch_ends: assert property (p_switch_ends) else $error("switch never ended");
  property p_busy_cause;
    $rose(busy_out) |-> $past(sw_start_in);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without a start");
  // ==================================================
  // Lazy context flag
  property p_lazy_on_resume;
    resume_out |-> lazy_context_flag_out;
  endproperty
  a_lazy_on_resume: assert property (p_lazy_on_resume) else $error("lazy flag clear");
  property p_media_fault;
    lazy_context_flag_out && media_op_in && !busy_out && !sw_start_in
      |-> ##[1:2] (fault_out && fault_code_out == `FLT_CU);
  endproperty
  a_media_fault: assert property (p_media_fault) else $error("media op not faulted");
  property p_lazy_sticky;
    lazy_context_flag_out && !reg_we_in |=> lazy_context_flag_out;
  endproperty
  a_lazy_sticky: assert property (p_lazy_sticky) else $error("lazy flag dropped");
  // ==================================================
  // Memory port
  property p_mem_only_busy;
    mem_req_out |-> busy_out;
  endproperty
  a_mem_only_busy: assert property (p_mem_only_busy) else $error("memory access idle");
  property p_mem_hold;
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("request not held");
endmodule // task_switch_sequencer_props

bind task_switch_sequencer task_switch_sequencer_props u_props (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_we_in(reg_we_in),
  .sw_start_in(sw_start_in), .sw_kind_in(sw_kind_in), .media_op_in(media_op_in),
  .busy_out(busy_out), .fault_out(fault_out), .fault_code_out(fault_code_out),
  .resume_out(resume_out), .lazy_context_flag_out(lazy_context_flag_out),
  .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in)
);

// >>> dv/task_memory_model.sv
`timescale 1ns/1ps
module task_memory_model (
  input  wire         clk_sys_in,
  input  wire         rst_in,
  input  wire         req_in,
  input  wire         we_in,
  input  wire [31:0]  addr_in,
  input  wire [31:0]  wdata_in,
  input  wire [7:0]   lat_in,
  output logic        ack_out,
  output logic [31:0] rdata_out
);
  // ==================================================
  // Tables and state segments, word addressed
  logic [31:0] word [0:1023];
  logic [7:0]  cnt;
  // Idle data toggles so a late sample never sees a stale word
  always @(posedge clk_sys_in) begin
    ack_out <= 1'b0;
    rdata_out <= rst_in ? 32'h0 : ~rdata_out;
    if (rst_in || !req_in || ack_out) begin
      cnt <= 8'h00;
    end else if (cnt < lat_in) begin
      cnt <= cnt + 8'h01;
    end else begin
      ack_out <= 1'b1;
      cnt <= 8'h00;
      if (we_in) begin
        word[addr_in[11:2]] <= wdata_in;
      end else begin
        rdata_out <= word[addr_in[11:2]];
      end
    end
  end
endmodule // task_memory_model

// >>> dv/task_switch_sequencer_test.sv
`timescale 1ns/1ps
`include "task_switch_regs.vh"
module task_switch_sequencer_test;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic        sw_start = 1'b0;
  logic [2:0]  sw_kind = 3'h0;
  logic [15:0] sw_sel = 16'h0;
  logic [7:0]  sw_vec = 8'h0;
  logic        media_op = 1'b0;
  logic [7:0]  lat = 8'h0;
  wire  [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, resume_ip;
  wire  [15:0] resume_cs;
  wire  [2:0]  fault_code;
  wire         busy, fault, resume, lazy, mem_req, mem_we, mem_ack;
  int          mismatches = 0;
  int          comparisons = 0;
  int          writes = 0;
  logic        seen_fault, seen_res, r;
  logic [31:0] d;
  logic [15:0] s;
  logic [2:0]  k, c;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (mem_req && mem_we && mem_ack) writes++;

  task_switch_sequencer uut (
    .clk_sys_in(clk_sys), .rst_in(rst), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_we_in(reg_we), .reg_re_in(reg_re), .reg_rdata_out(reg_rdata),
    .sw_start_in(sw_start), .sw_kind_in(sw_kind), .sw_sel_in(sw_sel), .sw_vec_in(sw_vec),
    .media_op_in(media_op), .busy_out(busy), .fault_out(fault), .fault_code_out(fault_code),
    .resume_out(resume), .resume_cs_out(resume_cs), .resume_ip_out(resume_ip),
    .lazy_context_flag_out(lazy), .mem_req_out(mem_req), .mem_we_out(mem_we),
    .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_ack_in(mem_ack),
    .mem_rdata_in(mem_rdata));
  task_memory_model far_mem (
    .clk_sys_in(clk_sys), .rst_in(rst), .req_in(mem_req), .we_in(mem_we), .addr_in(mem_addr),
    .wdata_in(mem_wdata), .lat_in(lat), .ack_out(mem_ack), .rdata_out(mem_rdata));

  // ==================================================
  // Helpers
  function automatic logic [31:0] std_hi(input logic p, input logic [1:0] l, input logic b);
    return {16'h0, p, l, 2'b01, 1'b0, b, 1'b1, 8'h00};
  endfunction
  function automatic logic [31:0] gate_hi(input logic p, input logic [1:0] l, input logic [4:0] t);
    return {16'h0, p, l, t, 8'h00};
  endfunction
  function automatic logic [31:0] ctx(input logic [31:0] top, input int i, input logic [15:0] cs);
    return i < 10 ? top + 32'(i) : (i == 11 ? {16'h0, cs} : 32'h20);
  endfunction
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    chk($sformatf("register %h", a), e, reg_rdata);
  endtask
  task automatic put(input int a, input logic [31:0] v);
    far_mem.word[a >> 2] = v;
  endtask
  task automatic go(input logic [2:0] kd, input logic [15:0] sl, input logic [7:0] vc);
    int n;
    @(posedge clk_sys);
    sw_start <= 1'b1;
    sw_kind <= kd;
    sw_sel <= sl;
    sw_vec <= vc;
    writes = 0;
    @(posedge clk_sys);
    sw_start <= 1'b0;
    seen_fault = 1'b0;
    seen_res = 1'b0;
    for (n = 0; n < 600 && !(seen_fault || seen_res); n++) begin
      @(negedge clk_sys);
      seen_fault = fault;
      seen_res = resume;
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic media(input logic e);
    int n;
    seen_fault = 1'b0;
    @(posedge clk_sys);
    media_op <= 1'b1;
    @(posedge clk_sys);
    media_op <= 1'b0;
    for (n = 0; n < 3; n++) begin
      @(negedge clk_sys);
      seen_fault = seen_fault | fault;
    end
    chk("media fault", e, seen_fault);
  endtask
  // Variant 0 is a clean jump, 14 a call and 15 an interrupt; the others each break one check or pass a boundary
  task automatic setup(input int v);
    int i;
    logic [1:0] current_privilege_level;
    current_privilege_level = v inside {1, 6, 14, 15} ? 2'h3 : (v == 12 ? 2'h2 : 2'h0);
    k = v == 14 ? `K_CALL : `K_JUMP;
    s = v == 2 ? 16'h13 : v inside {5, 6, 7, 9} ? 16'h18 : v inside {8, 13} ? 16'h0c :
        v == 12 ? 16'h1a : v == 14 ? 16'h1b : 16'h10;
    c = v inside {3, 11} ? `FLT_IS : v inside {4, 5} ? `FLT_AB :
        v inside {0, 12, 13, 14, 15} ? `FLT_NONE : `FLT_PR;
    r = v inside {0, 11, 12, 13, 14, 15};
    for (i = 0; i < 1024; i++) far_mem.word[i] = 32'h0;
    put('h108, 32'h04000067);
    put('h10c, std_hi(1'b1, 2'h0, 1'b1));
    put('h110, v == 3 ? 32'h05000066 : 32'h05000067);
    put('h114, std_hi(v != 4, 2'h0, v == 10));
    put('h118, 32'h00100000);
    put('h11c, gate_hi(v != 5, v == 6 ? 2'h0 : v == 12 ? 2'h2 : 2'h3, v == 7 ? 5'h04 : `TYPE_GATE));
    put('h124, 32'h00009300);
    put('h12c, 32'h00001300);
    put('h218, 32'h00100000);
    put('h21c, gate_hi(1'b1, 2'h0, `TYPE_GATE));
    put('h308, v == 8 ? 32'h05000067 : 32'h00100000);
    put('h30c, v == 8 ? std_hi(1'b1, 2'h0, 1'b0) : gate_hi(1'b1, 2'h3, `TYPE_GATE));
    put('h51c, 32'h5000);
    put('h560, 32'h58);
    for (i = 0; i < 16; i++) begin
      put('h420 + 4 * i, ctx(32'ha0000000, i, 16'h20));
      put('h520 + 4 * i, ctx(32'hb0000000, i, v == 11 ? 16'h2b : 16'h23));
      wr(8'h40 + 8'(4 * i), ctx(32'hc0000000, i, {14'h0, current_privilege_level} | 16'h20));
    end
    wr(`OFF_CTRL, v == 9 ? 32'h2 : 32'h0);
    wr(`OFF_GDTB, 32'h100);
    wr(`OFF_IDTB, 32'h200);
    wr(`OFF_LDTB, 32'h300);
    wr(`OFF_TRSEL, 32'h8);
    wr(`OFF_TRBASE, 32'h400);
  endtask

  // ==================================================
  // Tests
  initial begin
    int i;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    setup(0);
    go(k, s, 8'h0);
    chk("resume", 1, seen_res);
    chk("saved writes", 18, writes);
    for (i = 0; i < 16; i++) chk("saved", ctx(32'hc0000000, i, 16'h20), far_mem.word[264 + i]);
    rdchk(`OFF_TRSEL, 32'h10);
    rdchk(`OFF_TRBASE, 32'h500);
    rdchk(`OFF_PTB, 32'h5000);
    rdchk(`OFF_LTR, 32'h58);
    rdchk(8'h40, 32'hb0000000);
    rdchk(`OFF_STAT, 32'h3f0);
    rdchk(`OFF_CTRL, 32'h1);
    chk("resume cs", 32'h23, {16'h0, resume_cs});
    chk("resume ip", 32'hb0000000, resume_ip);
    chk("old busy", 0, far_mem.word['h10c >> 2][9]);
    chk("new busy", 1, far_mem.word['h114 >> 2][9]);
    media(1'b1);
    chk("fault code", `FLT_CU, fault_code);
    wr(`OFF_CTRL, 32'h0);
    media(1'b0);
    lat <= 8'h03;
    setup(14);
    go(k, s, 8'h0);
    chk("resume", 1, seen_res);
    chk("link", 32'h8, {16'h0, far_mem.word['h500 >> 2][15:0]});
    chk("old busy", 1, far_mem.word['h10c >> 2][9]);
    chk("gate", gate_hi(1'b1, 2'h3, `TYPE_GATE), far_mem.word['h11c >> 2]);
    wr(8'h44, 32'h4000);
    go(`K_IRTN, 16'h0, 8'h0);
    chk("resume", 1, seen_res);
    rdchk(`OFF_TRSEL, 32'h8);
    chk("old busy", 0, far_mem.word['h114 >> 2][9]);
    go(`K_IRTN, 16'h0, 8'h0);
    chk("answer", 0, seen_res | seen_fault);
    for (i = 2; i <= 3; i++) begin
      setup(15);
      go(3'(i), 16'h0, 8'h03);
      chk("resume", 1, seen_res);
      chk("link", 32'h8, {16'h0, far_mem.word['h500 >> 2][15:0]});
    end
    for (i = 1; i <= 13; i++) begin
      lat <= i[0] ? 8'h02 : 8'h00;
      setup(i);
      go(k, s, 8'h0);
      chk("resume", r, seen_res);
      chk("fault", c != `FLT_NONE, seen_fault);
      if (c != `FLT_NONE) chk("fault code", c, fault_code);
      if (!r) chk("abort writes", 0, writes);
      if (!r) rdchk(`OFF_TRSEL, 32'h8);
      if (i == 11) rdchk(`OFF_STAT, 32'h3d6);
    end
    conclude();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end
endmodule // task_switch_sequencer_test
